/* irc_codec.sv */
// half-duplex infrared pulse encoder and decoder, 16x bit clock
`timescale 1ns/1ps
// Functional notes
// - zero in gives pulse after 7 ticks
// - receive low reaches host after 4 ticks
// - bit timing from 16x bit clock edges, pulse limit and minimum low from system clock
// - sixteen ticks per bit, ten-bit frame
// - baud equals bit clock over sixteen
// - zero bit: low 7, high 3, low rest
// - one bit: no pulse whole bit time
// - limiter ends any pulse near 4 us
// - early low of 1.6 us decodes zero
// - host output holds each bit 16 ticks, the last bit 12 before the frame end sets it high
// - reset drives host high, infrared low
// - receive pulse suppresses transmit pulse
module irc_codec #(
    parameter logic [7:0] LIMIT_CYC = irc_pkg::TX_LIMIT_CYC,
    parameter logic [7:0] MIN_LOW   = irc_pkg::RX_MIN_CYC
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic arst_n,
    // 16x bit clock pin
    input  wire logic bit_clock_16x,
    // host uart side
    input  wire logic host_tx_in,
    output logic      host_rx_out,
    // infrared transceiver side
    input  wire logic ir_rx_in,
    output logic      ir_tx_out
);
    import irc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic [2:0] pin_q;
    logic       clk16_prev_r;
    logic       host_prev_r;
    logic       rx_prev_r;

    irc_sync2 #(
        .W       (3),
        .RST_VAL (3'h7)
    ) u_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pin_in  ({bit_clock_16x, host_tx_in, ir_rx_in}),
        .sync_q  (pin_q)
    );

    wire clk16_q = pin_q[2];
    wire host_q  = pin_q[1];
    wire rx_q    = pin_q[0];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clk16_prev_r <= 1'b1;
            host_prev_r  <= 1'b1;
            rx_prev_r    <= 1'b1;
        end else begin
            clk16_prev_r <= clk16_q;
            host_prev_r  <= host_q;
            rx_prev_r    <= rx_q;
        end
    end

    // a stopped bit clock simply freezes both framers
    wire bit_clock_tick = clk16_q & ~clk16_prev_r;
    wire host_fall      = ~host_q & host_prev_r;
    wire rx_fall        = ~rx_q & rx_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // receive decoder
    irc_state_t rx_st_r;
    irc_state_t rx_st_nxt;
    logic [3:0] rx_ph_r;
    logic [3:0] rx_bit_r;
    logic [7:0] rx_low_r;
    logic       host_rx_r;

    wire rx_busy  = (rx_st_r == IRC_BUSY);
    wire rx_start = ~rx_busy & rx_fall;
    wire rx_ptick = rx_busy & bit_clock_tick;
    wire rx_dec   = rx_ptick & (rx_ph_r == RX_DEC_PH);
    wire rx_bend  = rx_ptick & (rx_ph_r == PH_LAST);
    wire rx_end   = rx_bend & (rx_bit_r == LAST_BIT);
    wire rx_zero  = (rx_low_r >= MIN_LOW);
    // a start glitch shorter than the minimum pulse is dropped
    wire rx_abort = rx_dec & (rx_bit_r == 4'h0) & ~rx_zero;
    wire rx_win   = rx_busy & (rx_ph_r <= RX_DEC_PH) & ~rx_q;
    wire rx_cnt   = rx_win & (rx_low_r != MIN_LOW);

    always_comb begin
        rx_st_nxt = rx_st_r;
        unique case (rx_st_r)
            IRC_IDLE: begin
                if (rx_start) rx_st_nxt = IRC_BUSY;
            end
            IRC_BUSY: begin
                if (rx_end || rx_abort) rx_st_nxt = IRC_IDLE;
            end
            default: rx_st_nxt = IRC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_st_r <= IRC_IDLE;
        end else begin
            rx_st_r <= rx_st_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_ph_r  <= 4'h0;
            rx_bit_r <= 4'h0;
        end else if (rx_start) begin
            rx_ph_r  <= 4'h0;
            rx_bit_r <= 4'h0;
        end else if (rx_ptick) begin
            rx_ph_r  <= 4'(rx_ph_r + 4'h1);
            rx_bit_r <= rx_bend ? 4'(rx_bit_r + 4'h1) : rx_bit_r;
        end
    end

    // low time is measured only in the early part of each bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_low_r <= 8'h00;
        end else if (rx_start) begin
            rx_low_r <= 8'h01;
        end else if (rx_dec) begin
            rx_low_r <= 8'h00;
        end else if (rx_cnt) begin
            rx_low_r <= 8'(rx_low_r + 8'h01);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            host_rx_r <= 1'b1;
        end else if (rx_end || rx_abort) begin
            host_rx_r <= 1'b1;
        end else if (rx_dec) begin
            host_rx_r <= ~rx_zero;
        end
    end

    assign host_rx_out = host_rx_r;

    ////////////////////////////////////////////////////////////////////////
    // transmit encoder
    irc_state_t tx_st_r;
    irc_state_t tx_st_nxt;
    logic [3:0] tx_ph_r;
    logic [3:0] tx_bit_r;
    logic [7:0] lim_r;
    logic       tx_pulse_r;

    wire tx_busy  = (tx_st_r == IRC_BUSY);
    // no new frame while the receiver is busy: the link is half duplex
    wire tx_start = ~tx_busy & host_fall & ~rx_busy & rx_q;
    wire tx_ptick = tx_busy & bit_clock_tick;
    wire tx_bend  = tx_ptick & (tx_ph_r == PH_LAST);
    wire tx_end   = tx_bend & (tx_bit_r == LAST_BIT);
    wire tx_on    = tx_ptick & (tx_ph_r == TX_ON_PH) & ~host_q
                    & rx_q;
    wire tx_off   = tx_ptick & (tx_ph_r == TX_OFF_PH);
    wire lim_hit  = tx_pulse_r & (lim_r == 8'(LIMIT_CYC - 8'h01));
    wire tx_nxt   = tx_on ? 1'b1
                  : (tx_off | lim_hit | ~rx_q) ? 1'b0
                  : tx_pulse_r;

    always_comb begin
        tx_st_nxt = tx_st_r;
        unique case (tx_st_r)
            IRC_IDLE: begin
                if (tx_start) tx_st_nxt = IRC_BUSY;
            end
            IRC_BUSY: begin
                if (tx_end) tx_st_nxt = IRC_IDLE;
            end
            default: tx_st_nxt = IRC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_st_r <= IRC_IDLE;
        end else begin
            tx_st_r <= tx_st_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_ph_r  <= 4'h0;
            tx_bit_r <= 4'h0;
        end else if (tx_start) begin
            tx_ph_r  <= 4'h0;
            tx_bit_r <= 4'h0;
        end else if (tx_ptick) begin
            tx_ph_r  <= 4'(tx_ph_r + 4'h1);
            tx_bit_r <= tx_bend ? 4'(tx_bit_r + 4'h1) : tx_bit_r;
        end
    end

    // limiter runs on the system clock so a slow bit clock cannot
    // stretch the emitter current
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lim_r      <= 8'h00;
            tx_pulse_r <= 1'b0;
        end else begin
            lim_r      <= tx_pulse_r ? 8'(lim_r + 8'h01) : 8'h00;
            tx_pulse_r <= tx_nxt;
        end
    end

    assign ir_tx_out = tx_pulse_r;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_reset_idle_levels: assert property (
        disable iff (1'b0)
        !arst_n |-> (host_rx_out && !ir_tx_out))
        else $error("outputs not idle during reset");

    a_tx_limit_cap: assert property (
        ir_tx_out |-> (lim_r < LIMIT_CYC))
        else $error("transmit pulse exceeds limiter time");

    a_tx_rise_phase: assert property (
        $rose(ir_tx_out) |-> (tx_busy && tx_ph_r == 4'h7))
        else $error("transmit pulse rose at wrong tick");

    a_tx_zero_only: assert property (
        $rose(ir_tx_out) |-> ($past(host_q) == 1'b0))
        else $error("pulse sent for a one bit");

    a_tx_pulse_end: assert property (
        (ir_tx_out && tx_ptick && tx_ph_r == 4'h9) |=> !ir_tx_out)
        else $error("pulse outlived its three ticks");

    a_half_duplex: assert property (
        !rx_q |=> !ir_tx_out)
        else $error("transmit while receive pulse present");

    a_rx_fall_phase: assert property (
        $fell(host_rx_out) |-> (rx_busy && rx_ph_r == 4'h4))
        else $error("host output fell at wrong tick");

    a_rx_hold_bit: assert property (
        $changed(host_rx_out) |-> $past(rx_dec || rx_end || rx_abort))
        else $error("host output changed inside a bit");

    a_rx_idle_high: assert property (
        (!rx_busy && !$past(rx_busy)) |-> host_rx_out)
        else $error("host output low with receiver idle");

    a_tick_single: assert property (
        bit_clock_tick |=> !bit_clock_tick)
        else $error("bit clock tick longer than one cycle");

    a_frame_length: assert property (
        (tx_busy && tx_bit_r == 4'h9 && tx_bend) |=> !tx_busy)
        else $error("transmit frame not ten bits");

    a_tx_idle_low: assert property (
        !tx_busy |-> !ir_tx_out)
        else $error("transmit pulse with encoder idle");

    a_tx_one_quiet: assert property (
        (tx_ptick && tx_ph_r == TX_ON_PH && host_q) |=> !ir_tx_out)
        else $error("pulse on tick seven of a one bit");

    // half duplex: a busy receiver keeps the encoder from starting
    a_tx_start_refused: assert property (
        (rx_busy && !tx_busy) |=> !tx_busy)
        else $error("transmit frame started while receiving");

    a_rx_start_edge: assert property (
        (rx_fall && !rx_busy) |=> (rx_busy && rx_low_r == 8'h01))
        else $error("receive start edge not taken");

    a_rx_short_drop: assert property (
        (rx_dec && rx_bit_r == 4'h0 && !rx_zero)
            |=> (!rx_busy && host_rx_out))
        else $error("short start pulse not dropped");

    a_rx_one_high: assert property (
        (rx_dec && rx_low_r == 8'h00) |=> host_rx_out)
        else $error("one bit not decoded high");

    a_rx_frame_end: assert property (
        (rx_bend && rx_bit_r == LAST_BIT) |=> (!rx_busy && host_rx_out))
        else $error("receive frame not ten bits");

endmodule : irc_codec

/* irc_pkg.sv */
// shared constants and types for the infrared pulse codec
package irc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // system clock
    localparam int unsigned SYS_CLK_HZ = 50_000_000;
    localparam int unsigned SYS_CLK_NS = 1_000_000_000 / SYS_CLK_HZ;

    ////////////////////////////////////////////////////////////////////////
    // bit timing; phases counted in ticks of the 16x bit clock
    localparam int unsigned TICKS_PER_BIT  = 16;
    localparam int unsigned BITS_PER_FRAME = 10;
    localparam int unsigned REF_BAUD       = 115_200;
    localparam int unsigned REF_CLK16_HZ   = TICKS_PER_BIT * REF_BAUD;

    localparam logic [3:0] PH_LAST    = 4'(TICKS_PER_BIT - 1);
    localparam logic [3:0] LAST_BIT   = 4'(BITS_PER_FRAME - 1);
    // pulse rises on the 7th tick of the bit and lasts 3 ticks
    localparam logic [3:0] TX_ON_PH   = 4'h6;
    localparam logic [3:0] TX_OFF_PH  = 4'h9;
    // received level reaches the host on the 4th tick of the bit
    localparam logic [3:0] RX_DEC_PH  = 4'h3;

    ////////////////////////////////////////////////////////////////////////
    // analog-like limits turned into system clock counts
    localparam int unsigned TX_LIMIT_NS = 4000;
    localparam int unsigned RX_MIN_NS   = 1600;
    localparam int unsigned TX_LIMIT_C  = TX_LIMIT_NS / SYS_CLK_NS;
    localparam int unsigned RX_MIN_C    =
        (RX_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [7:0] TX_LIMIT_CYC = 8'((TX_LIMIT_C < 1) ? 1
                                              : TX_LIMIT_C);
    localparam logic [7:0] RX_MIN_CYC   = 8'((RX_MIN_C < 1) ? 1
                                              : RX_MIN_C);

    ////////////////////////////////////////////////////////////////////////
    // frame state
    typedef enum logic [1:0] {
        IRC_IDLE = 2'b01,
        IRC_BUSY = 2'b10
    } irc_state_t;

endpackage : irc_pkg

/* irc_sync2.sv */
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module irc_sync2 #(
    parameter int unsigned    W       = 1,
    parameter logic [W-1:0]   RST_VAL = '1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    // pins in, synchronised levels out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_q
);

    logic [W-1:0] meta_r;

    // meta_r feeds only the second stage
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_r <= pin_in;
            sync_q <= meta_r;
        end
    end

endmodule : irc_sync2

/* irc_far_end.sv */
// far side model: bit clock source and infrared transceiver
`timescale 1ns/1ps
module irc_far_end (
    // clock and bit clock control
    input  wire logic       clk_sys,
    input  wire logic       clk_run,
    input  wire logic [7:0] half_cyc,
    // pins toward the codec
    output logic            bit_clock_16x,
    output logic            ir_rx_in
);
    logic [7:0] cnt_r;

    initial begin
        bit_clock_16x = 1'b0;
        ir_rx_in      = 1'b1;
        cnt_r         = 8'h00;
    end

    // steady rate; half_cyc is read every cycle, so a new rate applies at once; parked when off
    always @(negedge clk_sys) begin
        if (!clk_run) begin
            bit_clock_16x <= 1'b0;
            cnt_r         <= 8'h00;
        end else if (cnt_r >= half_cyc - 8'h01) begin
            bit_clock_16x <= ~bit_clock_16x;
            cnt_r         <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // zero: low over the first three bit clocks; one: high all sixteen
    task automatic ir_bit(input logic b);
        ir_rx_in = b;
        repeat (6 * half_cyc) @(negedge clk_sys);
        ir_rx_in = 1'b1;
        repeat (26 * half_cyc) @(negedge clk_sys);
    endtask : ir_bit

    // plain low level of n cycles, for too short or overlapping pulses
    task automatic ir_low(input int n);
        ir_rx_in = 1'b0;
        repeat (n) @(negedge clk_sys);
        ir_rx_in = 1'b1;
    endtask : ir_low
endmodule : irc_far_end

/* tb.sv */
// self-checking bench for the infrared pulse codec
`timescale 1ns/1ps
module tb;
    import irc_pkg::*;
    // short limiter and minimum pulse so both show at a slow bit clock
    localparam logic [7:0] LIM  = 8'h28;
    localparam logic [7:0] MINL = 8'h14;
    logic       clk_sys = 1'b0;
    logic       arst_n = 1'b1;
    logic       clk_run;
    logic [7:0] half_cyc;
    logic       bit_clock_16x;
    logic       host_tx_in;
    logic       host_rx_out;
    logic       ir_rx_in;
    logic       ir_tx_out;
    int         fails;
    int         n_compared;

    always #(SYS_CLK_NS / 2) clk_sys = ~clk_sys;

    irc_codec #(.LIMIT_CYC(LIM), .MIN_LOW(MINL)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .bit_clock_16x(bit_clock_16x),
        .host_tx_in(host_tx_in), .host_rx_out(host_rx_out),
        .ir_rx_in(ir_rx_in), .ir_tx_out(ir_tx_out));
    irc_far_end u_far (
        .clk_sys(clk_sys), .clk_run(clk_run), .half_cyc(half_cyc),
        .bit_clock_16x(bit_clock_16x), .ir_rx_in(ir_rx_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic check_lvl(input string what, input logic e, input logic s);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, s);
        end
    endtask : check_lvl

    task automatic check_rng(input string what, input int lo, input int hi,
                             input int s);
        n_compared++;
        if (s < lo || s > hi) begin
            fails++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d",
                     what, lo, hi, s);
        end
    endtask : check_rng

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic idle(input int ticks);
        repeat (ticks * 2 * half_cyc) @(negedge clk_sys);
    endtask : idle

    // host frame; every window judged for pulse presence, zero windows for width, start window for delay
    task automatic tx_frame(input logic [7:0] d, input int wlo, input int whi);
        logic [9:0] fr;
        int t;
        int hi;
        int first;
        fr = {1'b1, d, 1'b0};
        t  = 2 * half_cyc;
        for (int k = 0; k < 10; k++) begin
            host_tx_in = fr[k];
            hi = 0;
            first = -1;
            for (int c = 0; c < 16 * t; c++) begin
                @(negedge clk_sys);
                if (ir_tx_out === 1'b1) begin
                    hi++;
                    first = (first < 0) ? c : first;
                end
            end
            check_lvl("tx pulse", ~fr[k], 1'(hi > 0));
            if (!fr[k]) begin
                check_rng("tx width", wlo, whi, hi);
            end
            if (k == 0) begin
                // seventh edge after the pin edge, plus pin latency
                check_rng("tx delay", 6 * t, 7 * t + 4, first);
            end
        end
    endtask : tx_frame

    // infrared frame; host level sampled ten ticks into each window, start bit timed
    task automatic rx_frame(input logic [7:0] d);
        logic [9:0] fr;
        int t;
        int first;
        int rise;
        fr = {1'b1, d, 1'b0};
        t = 2 * half_cyc;
        first = -1;
        rise = -1;
        fork
            for (int k = 0; k < 10; k++) u_far.ir_bit(fr[k]);
            for (int c = 0; c < 160 * t; c++) begin
                @(negedge clk_sys);
                if (first < 0 && host_rx_out === 1'b0) begin
                    first = c;
                end else if (first >= 0 && rise < 0
                             && host_rx_out === 1'b1) begin
                    rise = c;
                end
                if (c % (16 * t) == 10 * t) begin
                    check_lvl("rx bit", fr[c / (16 * t)], host_rx_out);
                end
            end
        join
        // fourth edge after the pin edge, plus pin latency
        check_rng("rx delay", 3 * t, 4 * t + 4, first);
        check_rng("rx start", 16 * t, 16 * t, rise - first);
    endtask : rx_frame

    task automatic rx_glitch();
        int lo;
        lo = 0;
        u_far.ir_low(10);
        repeat (32 * half_cyc) begin
            @(negedge clk_sys);
            lo += (host_rx_out !== 1'b1) ? 1 : 0;
        end
        check_rng("short pulse", 0, 0, lo);
        idle(176);
    endtask : rx_glitch

    // host zero while a receive pulse is on the line
    task automatic half_duplex();
        int hi;
        int n;
        hi = 0;
        fork
            u_far.ir_low(32 * half_cyc);
            begin
                @(negedge clk_sys);
                host_tx_in = 1'b0;
                repeat (28 * half_cyc) begin
                    @(negedge clk_sys);
                    hi += (ir_tx_out !== 1'b0) ? 1 : 0;
                end
                host_tx_in = 1'b1;
            end
        join
        check_rng("tx while rx", 0, 0, hi);
        idle(192);
        // receive pulse arriving inside a transmit pulse must cut it
        n = 0;
        host_tx_in = 1'b0;
        while (ir_tx_out !== 1'b1 && n < 32 * half_cyc) begin
            @(negedge clk_sys);
            n++;
        end
        check_lvl("tx rise", 1'b1, ir_tx_out);
        u_far.ir_low(4);
        check_lvl("tx cut", 1'b0, ir_tx_out);
        host_tx_in = 1'b1;
        idle(192);
    endtask : half_duplex

    task automatic mid_reset();
        fork
            u_far.ir_bit(1'b0);
        join_none
        repeat (20 * half_cyc) @(negedge clk_sys);
        check_lvl("rx low", 1'b0, host_rx_out);
        arst_n = 1'b0;
        #1;
        check_lvl("mid reset host", 1'b1, host_rx_out);
        check_lvl("mid reset ir", 1'b0, ir_tx_out);
        repeat (6) @(negedge clk_sys);
        arst_n = 1'b1;
        idle(32);
    endtask : mid_reset

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_run = 1'b1;
        half_cyc = 8'h06;
        host_tx_in = 1'b1;
        fails = 0;
        n_compared = 0;
        // reset falls just after time zero so every process sees the edge
        #1;
        arst_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        check_lvl("reset host", 1'b1, host_rx_out);
        check_lvl("reset ir", 1'b0, ir_tx_out);
        arst_n = 1'b1;
        idle(16);
        tx_frame(8'h35, 6 * half_cyc, 6 * half_cyc);
        idle(16);
        tx_frame(8'hca, 6 * half_cyc, 6 * half_cyc);
        idle(32);
        rx_frame(8'ha5);
        idle(32);
        rx_glitch();
        half_duplex();
        mid_reset();
        // park the bit clock between characters, then resume slower
        clk_run = 1'b0;
        idle(8);
        check_lvl("parked host", 1'b1, host_rx_out);
        check_lvl("parked ir", 1'b0, ir_tx_out);
        // slower bit clock: three clocks now outlast the limiter
        half_cyc = 8'h0a;
        clk_run = 1'b1;
        idle(32);
        tx_frame(8'h00, LIM, LIM + 1);
        idle(32);
        rx_frame(8'h5b);
        conclude();
    end
endmodule : tb
